// ---- verilog/pse_host_ctl.sv ----
// Host control block of the four-port power sourcing controller
`timescale 1ns/1ps
`include "pse_regs.svh"
module pse_host_ctl #(
  parameter int OC_TIMEOUT_CYC = `PSE_OC_TIMEOUT_CYC,
  parameter int GLITCH_CYC = `PSE_GLITCH_CYC
) (
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  // Chip pins and straps
  input wire logic chip_reset_n_in,
  input wire logic midspan_sel_in,
  input wire logic addr_strap_3_in,
  input wire logic addr_strap_2_in,
  input wire logic addr_strap_1_in,
  input wire logic addr_strap_0_in,
  // Serial data pins
  input wire logic serial_data_in,
  output logic serial_data_out_out,
  output logic serial_data_oe_n_out,
  // Interrupt pin
  output logic irq_n_out,
  output logic irq_oe_n_out,
  // Port pins
  input wire logic port_off_n_1_in,
  input wire logic port_off_n_2_in,
  input wire logic port_off_n_3_in,
  input wire logic port_off_n_4_in,
  input wire logic [3:0] above_cut_in,
  input wire logic [3:0] at_limit_in,
  output logic [3:0] fet_drive_out,
  output logic [3:0] fet_limit_out,
  output logic midspan_mode_out
);
  localparam int STOP_CYC = `PSE_STOP_TO_IRQ_CYC;
  localparam int GW = $clog2(GLITCH_CYC + 1);

  // Link domain: data bit taken on each serial clock rise
  logic link_bit;
  always_ff @(posedge scl_in) begin
    link_bit <= serial_data_in;
  end

  // Pin synchronisers
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;
  logic rstn_m;
  logic rstn_s;
  logic mid_m;
  logic mid_s;
  logic [3:0] strap_m;
  logic [3:0] strap_s;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {rstn_m, rstn_s} <= 2'h3;
      {mid_m, mid_s} <= 2'h0;
      strap_m <= 4'h0;
      strap_s <= 4'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {serial_data_in, sda_m, sda_s};
      {rstn_m, rstn_s} <= {chip_reset_n_in, rstn_m};
      {mid_m, mid_s} <= {midspan_sel_in, mid_m};
      strap_m <= {addr_strap_3_in, addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
      strap_s <= strap_m;
    end
  end

  // Chip reset glitch filter
  logic [GW-1:0] rf_cnt;
  logic chip_rst;
  logic core_rst;

  always_ff @(posedge core_clk_in) begin
    if (rst_in || rstn_s) begin
      rf_cnt <= '0;
      chip_rst <= 1'b0;
    end else if (rf_cnt == GW'(GLITCH_CYC - 1)) begin
      chip_rst <= 1'b1;
    end else begin
      rf_cnt <= rf_cnt + 1'b1;
    end
  end

  assign core_rst = rst_in || chip_rst;
  assign midspan_mode_out = mid_s;

  // Bus conditions
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic [6:0] own_addr;

  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign own_addr = {`PSE_ADDR_FIXED, strap_s};

  // Bus target state
  pse_pkg::pse_bus_state_t state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift;
  logic [7:0] tx_shift;
  logic [7:0] ptr;
  logic rd_mode;
  logic ara_mode;
  logic mack_ok;
  logic busy;
  logic irq_drive;
  logic [7:0] ev_flags;
  logic [7:0] event_mask;

  logic byte_done;
  logic addr_hit;
  logic ara_hit;
  logic wr_stb;
  logic ara_done;
  logic sda_drive;
  logic [7:0] rd_data;
  logic [7:0] tx_byte;

  assign byte_done = (state == pse_pkg::S_RX) && scl_fall && (bit_cnt == 4'h8);
  assign addr_hit = (shift[7:1] == own_addr);
  assign ara_hit = (shift[7:1] == `PSE_ARA_ADDR) && shift[0] && irq_drive;
  assign wr_stb = byte_done && (byte_idx == 2'h2);
  assign ara_done = (state == pse_pkg::S_ACK) && scl_fall && ara_mode;
  assign tx_byte = ara_mode ? {own_addr, 1'b0} : rd_data;
  assign rd_data = (ptr == `PSE_REG_EVENTS) ? ev_flags :
                   (ptr == `PSE_REG_EVENT_MASK) ? event_mask :
                   (ptr == `PSE_REG_PORT_STATE) ? {4'h0, fet_drive_out} :
                   (ptr == `PSE_REG_PIN_STATUS) ? {3'h0, strap_s, mid_s} : 8'h00;

  // Open-drain data output, separate from the data input
  assign sda_drive = (state == pse_pkg::S_ACK) || ((state == pse_pkg::S_TX) && !tx_shift[7]);
  assign serial_data_out_out = 1'b0;
  assign serial_data_oe_n_out = !sda_drive;

  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      busy <= 1'b0;
    end else if (start_c) begin
      busy <= 1'b1;
    end else if (stop_c) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      state <= pse_pkg::S_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
      ptr <= 8'h00;
      rd_mode <= 1'b0;
      ara_mode <= 1'b0;
      mack_ok <= 1'b0;
    end else if (start_c) begin
      state <= pse_pkg::S_RX;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
    end else if (stop_c) begin
      state <= pse_pkg::S_IDLE;
    end else begin
      case (state)
        pse_pkg::S_RX: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            shift <= {shift[6:0], link_bit};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            bit_cnt <= 4'h0;
            if (byte_idx == 2'h0) begin
              rd_mode <= shift[0];
              ara_mode <= ara_hit && !addr_hit;
              state <= (addr_hit || ara_hit) ? pse_pkg::S_ACK : pse_pkg::S_IDLE;
            end else begin
              if (byte_idx == 2'h1) begin
                ptr <= shift;
              end
              state <= pse_pkg::S_ACK;
            end
          end
        end
        pse_pkg::S_ACK: begin
          if (scl_fall) begin
            if (byte_idx != 2'h2) begin
              byte_idx <= byte_idx + 2'h1;
            end
            tx_shift <= tx_byte;
            bit_cnt <= 4'h0;
            state <= rd_mode ? pse_pkg::S_TX : pse_pkg::S_RX;
          end
        end
        pse_pkg::S_TX: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            tx_shift <= {tx_shift[6:0], 1'b0};
            if (bit_cnt == 4'h7) begin
              state <= pse_pkg::S_MACK;
            end
          end
        end
        pse_pkg::S_MACK: begin
          if (scl_rise) begin
            mack_ok <= !link_bit;
          end
          if (scl_fall) begin
            state <= mack_ok ? pse_pkg::S_TX : pse_pkg::S_IDLE;
            tx_shift <= tx_byte;
            bit_cnt <= 4'h0;
          end
        end
        default: state <= pse_pkg::S_IDLE;
      endcase
    end
  end

  // Register writes
  logic [3:0] port_rst_req;
  logic [3:0] power_req;
  logic irq_rel;
  logic [3:0] start_ev;
  logic [3:0] cut_ev;
  logic [7:0] new_ev;
  logic irq_cause;

  assign port_rst_req = (wr_stb && ptr == `PSE_REG_PORT_RESET) ? shift[3:0] : 4'h0;
  assign power_req = (wr_stb && ptr == `PSE_REG_POWER_ON) ? shift[3:0] : 4'h0;
  assign irq_rel = wr_stb && (ptr == `PSE_REG_PORT_RESET) &&
                   (shift[`PSE_IRQ_REL_BIT_LO] || shift[`PSE_IRQ_REL_BIT_HI]);
  assign new_ev = {cut_ev, start_ev};
  assign irq_cause = |(ev_flags & event_mask);

  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      event_mask <= `PSE_EVENT_MASK_RESET;
    end else if (wr_stb && ptr == `PSE_REG_EVENT_MASK) begin
      event_mask <= shift;
    end
  end

  // Sticky events; a new event wins over a release
  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      ev_flags <= 8'h00;
    end else begin
      ev_flags <= new_ev | (ev_flags & ~{8{irq_rel || ara_done}});
    end
  end

  // Interrupt pin follows the cause only while the bus is idle
  always_ff @(posedge core_clk_in) begin
    if (core_rst) begin
      irq_drive <= 1'b0;
    end else if (!busy) begin
      irq_drive <= irq_cause;
    end
  end

  assign irq_n_out = 1'b0;
  assign irq_oe_n_out = !irq_drive;

  // Four port instances
  logic [3:0] off_n;
  assign off_n = {port_off_n_4_in, port_off_n_3_in, port_off_n_2_in, port_off_n_1_in};

  for (genvar g = 0; g < 4; g++) begin : g_port
    pse_port #(
      .OC_TIMEOUT_CYC(OC_TIMEOUT_CYC),
      .GLITCH_CYC(GLITCH_CYC)
    ) u_port (
      .core_clk_in(core_clk_in),
      .rst_in(core_rst),
      .port_off_n_in(off_n[g]),
      .above_cut_in(above_cut_in[g]),
      .at_limit_in(at_limit_in[g]),
      .power_on_in(power_req[g]),
      .reset_bit_in(port_rst_req[g]),
      .fet_drive_out(fet_drive_out[g]),
      .fet_limit_out(fet_limit_out[g]),
      .start_event_out(start_ev[g]),
      .cut_event_out(cut_ev[g])
    );
  end

  property p_irq_fast;
    @(posedge core_clk_in) disable iff (core_rst)
    (irq_cause && !busy) |=> !irq_oe_n_out;
  endproperty
  a_irq_fast: assert property (p_irq_fast) else $error("interrupt late on idle bus");

  property p_irq_hold;
    @(posedge core_clk_in) disable iff (core_rst)
    busy |=> $stable(irq_oe_n_out);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt moved during transfer");

  property p_irq_stop;
    @(posedge core_clk_in) disable iff (core_rst)
    ($fell(busy) && irq_cause) |-> ##[1:STOP_CYC] (!irq_oe_n_out || !irq_cause);
  endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("interrupt late after stop");

  property p_irq_masked;
    @(posedge core_clk_in) disable iff (core_rst)
    ((ev_flags & event_mask) == 8'h00 && !busy) |=> irq_oe_n_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked event pulled interrupt");

  property p_irq_release;
    @(posedge core_clk_in) disable iff (core_rst)
    ((irq_rel || ara_done) && new_ev == 8'h00) |=> ev_flags == 8'h00;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("release left events set");

  property p_addr_ack;
    @(posedge core_clk_in) disable iff (core_rst)
    (byte_done && byte_idx == 2'h0 && shift[7:1] == own_addr && !start_c && !stop_c)
      |=> (state == pse_pkg::S_ACK) && !serial_data_oe_n_out;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_sda_idle;
    @(posedge core_clk_in) disable iff (core_rst)
    (state == pse_pkg::S_IDLE || state == pse_pkg::S_RX) |-> serial_data_oe_n_out;
  endproperty
  a_sda_idle: assert property (p_sda_idle) else $error("data driven while receiving");

  property p_rst_filter;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(chip_rst) |-> $past(rf_cnt) == GW'(GLITCH_CYC - 1) && !$past(rstn_s);
  endproperty
  a_rst_filter: assert property (p_rst_filter) else $error("chip reset filter too short");
endmodule

// ---- verilog/pse_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the host control block
`ifndef PSE_REGS_SVH
`define PSE_REGS_SVH

`define PSE_CLK_MHZ 40.0

`define PSE_REG_EVENTS 8'h00
`define PSE_REG_EVENT_MASK 8'h01
`define PSE_REG_PORT_STATE 8'h0c
`define PSE_REG_PIN_STATUS 8'h11
`define PSE_REG_POWER_ON 8'h19
`define PSE_REG_PORT_RESET 8'h1a

`define PSE_EVENT_MASK_RESET 8'h00
`define PSE_IRQ_REL_BIT_LO 6
`define PSE_IRQ_REL_BIT_HI 7

`define PSE_ADDR_FIXED 3'h2
`define PSE_ARA_ADDR 7'h0c

`define PSE_GLITCH_US 1.0
`define PSE_GLITCH_CYC $rtoi($ceil(`PSE_GLITCH_US * `PSE_CLK_MHZ))
`define PSE_FAULT_TO_IRQ_NS 150.0
`define PSE_FAULT_TO_IRQ_CYC $rtoi($floor(`PSE_FAULT_TO_IRQ_NS * `PSE_CLK_MHZ / 1000.0))
`define PSE_STOP_TO_IRQ_US 1.5
`define PSE_STOP_TO_IRQ_CYC $rtoi($floor(`PSE_STOP_TO_IRQ_US * `PSE_CLK_MHZ))
`define PSE_OC_TIMEOUT_MS 62.5
`define PSE_OC_TIMEOUT_CYC $rtoi($floor(`PSE_OC_TIMEOUT_MS * 1000.0 * `PSE_CLK_MHZ))

`endif

// ---- verilog/pse_pkg.sv ----
// Types of the host control block
package pse_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX = 5'h02,
    S_ACK = 5'h04,
    S_TX = 5'h08,
    S_MACK = 5'h10
  } pse_bus_state_t;

  typedef enum logic [2:0] {
    P_OFF = 3'h1,
    P_START = 3'h2,
    P_ON = 3'h4
  } pse_port_state_t;
endpackage

// ---- verilog/pse_port.sv ----
// One power port: shutdown filter, fault timer and transistor drive
`timescale 1ns/1ps
`include "pse_regs.svh"
module pse_port #(
  parameter int OC_TIMEOUT_CYC = `PSE_OC_TIMEOUT_CYC,
  parameter int GLITCH_CYC = `PSE_GLITCH_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Pins and comparators
  input wire logic port_off_n_in,
  input wire logic above_cut_in,
  input wire logic at_limit_in,
  // Register requests
  input wire logic power_on_in,
  input wire logic reset_bit_in,
  // Outputs
  output logic fet_drive_out,
  output logic fet_limit_out,
  output logic start_event_out,
  output logic cut_event_out
);
  localparam int TW = $clog2(OC_TIMEOUT_CYC + 1);
  localparam int GW = $clog2(GLITCH_CYC + 1);

  logic [2:0] in_m;
  logic [2:0] in_s;
  logic [GW-1:0] off_cnt;
  logic off_filt;
  logic [TW-1:0] timer;
  pse_pkg::pse_port_state_t state;
  logic cut_s;
  logic lim_s;
  logic expire;
  logic kill;
  logic powered;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      in_m <= 3'h1;
      in_s <= 3'h1;
    end else begin
      in_m <= {at_limit_in, above_cut_in, port_off_n_in};
      in_s <= in_m;
    end
  end

  assign cut_s = in_s[1];
  assign lim_s = in_s[2];
  assign powered = (state != pse_pkg::P_OFF);
  assign expire = powered && cut_s && (timer == TW'(OC_TIMEOUT_CYC - 1));
  assign kill = off_filt || reset_bit_in;
  assign fet_drive_out = powered;

  // Shutdown glitch filter
  always_ff @(posedge core_clk_in) begin
    if (rst_in || in_s[0]) begin
      off_cnt <= '0;
      off_filt <= 1'b0;
    end else if (off_cnt == GW'(GLITCH_CYC - 1)) begin
      off_filt <= 1'b1;
    end else begin
      off_cnt <= off_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || kill) begin
      state <= pse_pkg::P_OFF;
      timer <= '0;
    end else begin
      case (state)
        pse_pkg::P_OFF: begin
          timer <= '0;
          if (power_on_in) begin
            state <= pse_pkg::P_START;
          end
        end
        pse_pkg::P_START, pse_pkg::P_ON: begin
          if (expire) begin
            state <= pse_pkg::P_OFF;
            timer <= '0;
          end else begin
            timer <= cut_s ? timer + 1'b1 : '0;
            if (state == pse_pkg::P_START && !lim_s) begin
              state <= pse_pkg::P_ON;
            end
          end
        end
        default: state <= pse_pkg::P_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fet_limit_out <= 1'b0;
      start_event_out <= 1'b0;
      cut_event_out <= 1'b0;
    end else begin
      fet_limit_out <= powered && lim_s && !kill && !expire;
      start_event_out <= expire && !kill && (state == pse_pkg::P_START);
      cut_event_out <= expire && !kill && (state == pse_pkg::P_ON);
    end
  end

  property p_port_kill;
    @(posedge core_clk_in) disable iff (rst_in)
    kill |=> !fet_drive_out && !fet_limit_out;
  endproperty
  a_port_kill: assert property (p_port_kill) else $error("port not off after shutdown");

  property p_port_filter;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(off_filt) |-> $past(off_cnt) == GW'(GLITCH_CYC - 1) && !$past(in_s[0]);
  endproperty
  a_port_filter: assert property (p_port_filter) else $error("shutdown filter too short");

  property p_port_count;
    @(posedge core_clk_in) disable iff (rst_in)
    (powered && cut_s && !kill && !expire) |=> timer == $past(timer) + 1'b1;
  endproperty
  a_port_count: assert property (p_port_count) else $error("fault timer not counting");

  property p_port_expire;
    @(posedge core_clk_in) disable iff (rst_in)
    (expire && !kill) |=> !fet_drive_out && (start_event_out || cut_event_out);
  endproperty
  a_port_expire: assert property (p_port_expire) else $error("timeout did not stop port");
endmodule

// ---- tb/pse_i2c_host.sv ----
// Serial bus controller model that drives the host control block
`timescale 1ns/1ps
module pse_i2c_host (
  // Bit clock
  input wire logic bclk_in,
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // Idle bus: clock and data held high
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge bclk_in);
  endtask
  // Start or repeated start, clock left low
  task automatic start();
    sda_pull_out <= 1'b0;
    tk(4);
    scl_out <= 1'b1;
    tk(17);
    sda_pull_out <= 1'b1;
    tk(9);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    tk(4);
    sda_pull_out <= 1'b1;
    tk(13);
    scl_out <= 1'b1;
    tk(9);
    sda_pull_out <= 1'b0;
    tk(1);
  endtask
  // Data changes only while clock is low
  task automatic xbit(input logic b, output logic r);
    tk(4);
    sda_pull_out <= ~b;
    tk(13);
    scl_out <= 1'b1;
    tk(4);
    r = sda_in;
    tk(5);
    scl_out <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] w, input logic nak, output logic [7:0] r,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xbit(w[i], r[i]);
    end
    xbit(nak, a);
    ack = ~a;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    start();
    xbyte({a, 1'b0}, 1'b1, r, k1);
    xbyte(p, 1'b1, r, k2);
    xbyte(d, 1'b1, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    start();
    xbyte({a, 1'b0}, 1'b1, r, k1);
    xbyte(p, 1'b1, r, k2);
    start();
    xbyte({a, 1'b1}, 1'b1, r, k3);
    xbyte(8'hff, 1'b1, d, r[0]);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic ara(input logic [6:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k;
    start();
    xbyte({a, 1'b1}, 1'b1, r, ok);
    xbyte(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule

// ---- tb/pse_host_ctl_tb.sv ----
// Self-checking bench of the host control block
`timescale 1ns/1ps
`include "pse_regs.svh"
module pse_host_ctl_tb;
  localparam int OC = 200;
  localparam int GL = 40;
  logic core_clk = 1'b0;
  logic bclk = 1'b0;
  logic rst = 1'b1;
  logic chip_n = 1'b1;
  logic mid = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [3:0] off_n = 4'hf;
  logic [3:0] cut = 4'h0;
  logic [3:0] lim = 4'h0;
  logic scl, pull, d_out, d_oe_n, irq_v, irq_oe_n, mid_out;
  logic [3:0] fet;
  logic [3:0] fet_lim;
  wire sda;
  int fails = 0;
  int n_tests = 0;
  logic [6:0] adr;
  logic [7:0] rv;
  logic ok;
  always #12.5 core_clk = ~core_clk;
  always #15.0 bclk = ~bclk;
  // Pulled-up data line shared by both drivers
  assign sda = ~pull & (d_oe_n | d_out);
  pse_i2c_host host (.bclk_in(bclk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  pse_host_ctl #(.OC_TIMEOUT_CYC(OC), .GLITCH_CYC(GL)) dut (
    .core_clk_in(core_clk), .rst_in(rst), .scl_in(scl), .chip_reset_n_in(chip_n),
    .midspan_sel_in(mid), .addr_strap_3_in(strap[3]), .addr_strap_2_in(strap[2]),
    .addr_strap_1_in(strap[1]), .addr_strap_0_in(strap[0]), .serial_data_in(sda),
    .serial_data_out_out(d_out), .serial_data_oe_n_out(d_oe_n), .irq_n_out(irq_v),
    .irq_oe_n_out(irq_oe_n), .port_off_n_1_in(off_n[0]), .port_off_n_2_in(off_n[1]),
    .port_off_n_3_in(off_n[2]), .port_off_n_4_in(off_n[3]), .above_cut_in(cut),
    .at_limit_in(lim), .fet_drive_out(fet), .fet_limit_out(fet_lim),
    .midspan_mode_out(mid_out));
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_irq(input logic e, input int n);
    for (int k = 0; k < n && irq_oe_n !== e; k++) @(negedge core_clk);
    chk1("irq_oe_n", e, irq_oe_n);
  endtask
  task automatic reg_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    host.rd(adr, a, rv, ok);
    chk8(nm, e, rv);
  endtask
  // Power a port and load it above the overcurrent threshold
  task automatic arm(input int i, input logic l);
    // Limit goes up before power on so that a limited port stays in start-up
    @(posedge core_clk);
    lim[i] <= l;
    host.wr(adr, `PSE_REG_POWER_ON, 8'h01 << i, ok);
    @(posedge core_clk);
    cut[i] <= 1'b1;
    wt(6);
    chk1("fet_limit", l, fet_lim[i]);
  endtask
  task automatic expire(input int i);
    int c;
    c = 0;
    while (fet[i] !== 1'b0 && c < OC + 20) begin
      @(negedge core_clk);
      c++;
    end
    chk1("fault_timer", 1'b1, c >= OC - 8 && c <= OC + 2);
    @(posedge core_clk);
    cut[i] <= 1'b0;
    lim[i] <= 1'b0;
  endtask
  task automatic pulse(input logic chip, input int i, input int n);
    @(posedge core_clk);
    if (chip) chip_n <= 1'b0;
    else off_n[i] <= 1'b0;
    repeat (n) @(posedge core_clk);
    chip_n <= 1'b1;
    off_n <= 4'hf;
    wt(6);
  endtask
  initial begin
    logic l;
    void'($urandom(32'h98d9_700c));
    @(posedge core_clk);
    strap <= 4'($urandom);
    mid <= 1'($urandom);
    repeat (7) @(posedge core_clk);
    rst <= 1'b0;
    wt(5);
    adr = {`PSE_ADDR_FIXED, strap};
    chk1("midspan_mode", mid, mid_out);
    chk1("irq_level", 1'b0, irq_v);
    reg_chk("pin_status", `PSE_REG_PIN_STATUS, {3'h0, strap, mid});
    host.wr(adr ^ 7'h01, `PSE_REG_EVENT_MASK, 8'hff, ok);
    chk1("other_addr_ack", 1'b0, ok);
    reg_chk("event_mask", `PSE_REG_EVENT_MASK, `PSE_EVENT_MASK_RESET);
    arm(0, 1'($urandom));
    expire(0);
    wt(10);
    chk1("irq_masked", 1'b1, irq_oe_n);
    host.wr(adr, `PSE_REG_EVENT_MASK, 8'hff, ok);
    wait_irq(1'b0, 58);
    for (int i = 0; i < 2; i++) begin
      host.wr(adr, `PSE_REG_PORT_RESET, (i == 0) ? 8'h40 : 8'h80, ok);
      wait_irq(1'b1, 58);
      l = 1'($urandom);
      arm(i + 1, l);
      expire(i + 1);
      wait_irq(1'b0, 5);
      reg_chk("events", `PSE_REG_EVENTS, l ? 8'h01 << (i + 1) : 8'h10 << (i + 1));
    end
    host.ara(`PSE_ARA_ADDR, rv, ok);
    chk1("ara_ack", 1'b1, ok);
    chk8("ara_reply", {adr, 1'b0}, rv);
    wait_irq(1'b1, 58);
    host.ara(`PSE_ARA_ADDR, rv, ok);
    chk1("ara_idle_ack", 1'b0, ok);
    arm(3, 1'($urandom));
    fork
      expire(3);
      begin
        host.start();
        host.xbyte({adr, 1'b0}, 1'b1, rv, ok);
        host.xbyte(`PSE_REG_EVENTS, 1'b1, rv, ok);
      end
    join
    chk1("irq_in_transfer", 1'b1, irq_oe_n);
    host.stop();
    wait_irq(1'b0, 58);
    host.wr(adr, `PSE_REG_PORT_RESET, 8'h40, ok);
    wait_irq(1'b1, 58);
    for (int i = 0; i < 4; i++) begin
      host.wr(adr, `PSE_REG_POWER_ON, 8'h0f, ok);
      pulse(1'b0, i, GL - 10);
      reg_chk("port_glitch", `PSE_REG_PORT_STATE, 8'h0f);
      pulse(1'b0, i, GL + 10);
      reg_chk("port_off", `PSE_REG_PORT_STATE, 8'h0f ^ (8'h01 << i));
      host.wr(adr, `PSE_REG_POWER_ON, 8'h0f, ok);
      host.wr(adr, `PSE_REG_PORT_RESET, 8'h01 << i, ok);
      reg_chk("port_rst", `PSE_REG_PORT_STATE, 8'h0f ^ (8'h01 << i));
    end
    reg_chk("events_none", `PSE_REG_EVENTS, 8'h00);
    host.wr(adr, `PSE_REG_POWER_ON, 8'h0f, ok);
    host.wr(adr, `PSE_REG_EVENT_MASK, 8'h5a, ok);
    pulse(1'b1, 0, GL - 10);
    reg_chk("mask_glitch", `PSE_REG_EVENT_MASK, 8'h5a);
    chk8("fet_glitch", 8'h0f, {4'h0, fet});
    pulse(1'b1, 0, GL + 10);
    chk8("fet_reset", 8'h00, {4'h0, fet});
    reg_chk("mask_reset", `PSE_REG_EVENT_MASK, `PSE_EVENT_MASK_RESET);
    give_verdict();
  end
  initial begin
    #2_000_000;
    fails++;
    $display("mismatch watchdog expected done seen timeout");
    give_verdict();
  end
endmodule
